// ---- design/cft_pkg.sv ----
// constants, opcode classes and timing table for the control-flow sequencer
//
// Operation
// - far call pushes return address, stack down two, loads full target
// - near call pushes like far call, replaces only low twelve bits
// - table jump loads low pc byte from rom at high pc, accumulator
// - return pops two, restores low byte and high part; 1 byte, 5 cycles
// - return-and-skip restores like return, then skips the next one
// - irq return restores like return and sets global interrupt enable
// - idle instruction only advances the program counter; 1/1
// - most opcodes are one byte; immediate forms take a second byte, except B immediate below 16
// - alu ops and compares: 1/1 via pointer, 3/4 direct, 2/2 immediate
// - bit ops 1/1, 3/4; dec-skip 1/3; nibble compare, clear pending 1/1
// - accumulator ops 1/1; table load, push, pop 1/3; mask test skip 2/2
// - far jump 3/4, page jump 2/3, short jump 1/3, vector dispatch 1/5
// - transfers 1/1 via B, 1/3 via X, 2/3 direct, auto-index 1/2 or 1/3
// - B immediate 1/1 below 16 else 2/2; other immediates per table
// - global irq enable is one status bit gating maskable interrupts
package cft_pkg;

  localparam int PC_W = 15;
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [7:0] SP_RESET = 8'h6f;
  localparam logic [14:0] TRAP_TARGET = 15'h00ff;
  localparam logic [7:0] B_SHORT_LIMIT = 8'h10;

  // instruction classes presented by the opcode decoder
  typedef enum logic [5:0] {
    OP_IDLE       = 6'h00, OP_CALL_FAR   = 6'h01, OP_CALL_NEAR  = 6'h02,
    OP_TABLE_JUMP = 6'h03, OP_EXIT       = 6'h04, OP_EXIT_SKIP  = 6'h05,
    OP_IRQ_EXIT   = 6'h06, OP_TRAP       = 6'h07, OP_ALU_B      = 6'h08,
    OP_ALU_DIR    = 6'h09, OP_ALU_IMM    = 6'h0a, OP_BIT_B      = 6'h0b,
    OP_BIT_DIR    = 6'h0c, OP_DEC_SKIP   = 6'h0d, OP_NIB_CMP    = 6'h0e,
    OP_CLR_PEND   = 6'h0f, OP_ACC        = 6'h10, OP_ROM_LOAD   = 6'h11,
    OP_ACC_PUSH   = 6'h12, OP_ACC_POP    = 6'h13, OP_MASK_SKIP  = 6'h14,
    OP_FAR_JUMP   = 6'h15, OP_PAGE_JUMP  = 6'h16, OP_SHORT_JUMP = 6'h17,
    OP_VECTOR     = 6'h18, OP_XFER_B     = 6'h19, OP_XFER_X     = 6'h1a,
    OP_XFER_DIR   = 6'h1b, OP_XFER_BIDX  = 6'h1c, OP_XFER_XIDX  = 6'h1d,
    OP_LD_A_IMM   = 6'h1e, OP_LD_B_IMM   = 6'h1f, OP_MEM_IMM_B  = 6'h20,
    OP_MEM_IMM_D  = 6'h21, OP_REG_IMM    = 6'h22, OP_CMP_DIR_IM = 6'h23
  } cft_op_type;

  // returns {bytes[1:0], cycles[2:0]}; imm matters only for B loads
  function automatic logic [4:0] cft_timing(input cft_op_type op,
                                            input logic [7:0] imm);
    logic [4:0] t;
    t = {2'h1, 3'h1};
    case (op)
      OP_CALL_FAR:   t = {2'h3, 3'h5};
      OP_CALL_NEAR:  t = {2'h2, 3'h5};
      OP_TABLE_JUMP: t = {2'h1, 3'h3};
      OP_EXIT, OP_EXIT_SKIP, OP_IRQ_EXIT, OP_VECTOR: t = {2'h1, 3'h5};
      OP_TRAP:       t = {2'h1, 3'h7};
      OP_ALU_DIR, OP_BIT_DIR, OP_FAR_JUMP: t = {2'h3, 3'h4};
      OP_ALU_IMM, OP_MASK_SKIP, OP_LD_A_IMM, OP_MEM_IMM_B: t = {2'h2, 3'h2};
      OP_DEC_SKIP, OP_ROM_LOAD, OP_ACC_PUSH, OP_ACC_POP, OP_SHORT_JUMP,
      OP_XFER_X, OP_XFER_XIDX: t = {2'h1, 3'h3};
      OP_PAGE_JUMP, OP_XFER_DIR, OP_REG_IMM: t = {2'h2, 3'h3};
      OP_XFER_BIDX:  t = {2'h1, 3'h2};
      OP_LD_B_IMM:   t = (imm < B_SHORT_LIMIT) ? {2'h1, 3'h1} : {2'h2, 3'h2};
      OP_MEM_IMM_D, OP_CMP_DIR_IM: t = {2'h3, 3'h3};
      default:       t = {2'h1, 3'h1};
    endcase
    return t;
  endfunction : cft_timing

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } cft_state_type;

endpackage : cft_pkg

// ---- design/cft_sequencer.sv ----
// control-flow and timing sequencer of the core
`timescale 1ns/1ps
module cft_sequencer (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // instruction issue from the opcode decoder
  input  wire logic        issue_valid,
  input  wire logic [5:0]  issue_op,
  input  wire logic [14:0] issue_operand,
  input  wire logic        issue_cond_fail,
  input  wire logic [7:0]  acc_value,
  output logic             issue_ready,
  output logic             instr_done,
  output logic             instr_skipped,
  // architectural state
  output logic [14:0]      pc,
  output logic [7:0]       stack_pointer,
  output logic             global_irq_enable,
  // data ram stack port, read data valid in the same cycle as the address
  output logic [7:0]       ram_addr,
  output logic             ram_we,
  output logic [7:0]       ram_wdata,
  input  wire logic [7:0]  ram_rdata,
  // program rom port
  output logic [14:0]      rom_addr,
  input  wire logic [7:0]  rom_rdata,
  // accumulator write-back
  output logic             acc_we,
  output logic [7:0]       acc_wdata
);

  // ****************************************************************
  // step decode
  // ****************************************************************
  cft_pkg::cft_state_type state_reg;
  cft_pkg::cft_op_type    op_reg;
  cft_pkg::cft_op_type    cur_op;
  logic [14:0] operand_reg;
  logic [14:0] ret_addr_reg;
  logic [14:0] pc_tmp_reg;
  logic [2:0]  cnt_reg;
  logic [2:0]  cur_k;
  logic [2:0]  cycles_reg;
  logic [2:0]  cur_cycles;
  logic [1:0]  cur_bytes;
  logic [4:0]  timing;
  logic [14:0] cur_operand;
  logic [14:0] cur_ret;
  logic        cond_reg;
  logic        skip_reg;
  logic        accept;
  logic        active;
  logic        last_step;

  always_comb begin
    cur_op = (state_reg == cft_pkg::ST_IDLE) ?
             cft_pkg::cft_op_type'(issue_op) : op_reg;
    timing      = cft_pkg::cft_timing(cur_op, issue_operand[7:0]);
    cur_bytes   = timing[4:3];
    // ready is low in the first cycle after reset: nothing is taken there
    accept      = (state_reg == cft_pkg::ST_IDLE) && issue_valid &&
                  issue_ready;
    active      = accept || (state_reg == cft_pkg::ST_EXEC);
    cur_k       = (state_reg == cft_pkg::ST_IDLE) ? 3'h0 : cnt_reg;
    cur_cycles  = (state_reg == cft_pkg::ST_IDLE) ? timing[2:0] : cycles_reg;
    cur_operand = (state_reg == cft_pkg::ST_IDLE) ? issue_operand
                                                  : operand_reg;
    cur_ret     = (state_reg == cft_pkg::ST_IDLE)
                  ? pc + {13'h0000, cur_bytes} : ret_addr_reg;
    last_step   = active && (cur_k == cur_cycles - 3'h1);
  end

  // ****************************************************************
  // sequencing
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg    <= cft_pkg::ST_IDLE;
      op_reg       <= cft_pkg::OP_IDLE;
      operand_reg  <= 15'h0000;
      ret_addr_reg <= 15'h0000;
      cycles_reg   <= 3'h1;
      cnt_reg      <= 3'h0;
      cond_reg     <= 1'b0;
      issue_ready  <= 1'b0;
    end else begin
      issue_ready <= 1'b0;
      case (state_reg)
        cft_pkg::ST_IDLE: begin
          issue_ready <= 1'b1;
          if (accept) begin
            op_reg       <= cur_op;
            operand_reg  <= issue_operand;
            ret_addr_reg <= cur_ret;
            cycles_reg   <= timing[2:0];
            cond_reg     <= issue_cond_fail;
            cnt_reg      <= 3'h1;
            // skipped ones finish in one cycle
            if (!skip_reg && !last_step) begin
              state_reg   <= cft_pkg::ST_EXEC;
              issue_ready <= 1'b0;
            end
          end
        end
        cft_pkg::ST_EXEC: begin
          cnt_reg <= cnt_reg + 3'h1;
          if (last_step) begin
            state_reg   <= cft_pkg::ST_IDLE;
            issue_ready <= 1'b1;
          end
        end
        default: state_reg <= cft_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // completion and skip
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      instr_done    <= 1'b0;
      instr_skipped <= 1'b0;
      skip_reg      <= 1'b0;
    end else begin
      instr_done    <= 1'b0;
      instr_skipped <= 1'b0;
      if (accept && skip_reg) begin
        // full length passed over, no effects
        instr_done    <= 1'b1;
        instr_skipped <= 1'b1;
        skip_reg      <= 1'b0;
      end else if (last_step) begin
        instr_done <= 1'b1;
        case (cur_op)
          cft_pkg::OP_EXIT_SKIP: skip_reg <= 1'b1;
          cft_pkg::OP_ALU_B, cft_pkg::OP_ALU_DIR, cft_pkg::OP_ALU_IMM,
          cft_pkg::OP_BIT_B, cft_pkg::OP_BIT_DIR, cft_pkg::OP_DEC_SKIP,
          cft_pkg::OP_NIB_CMP, cft_pkg::OP_MASK_SKIP, cft_pkg::OP_ACC,
          cft_pkg::OP_CMP_DIR_IM:
            skip_reg <= (state_reg == cft_pkg::ST_IDLE) ? issue_cond_fail
                                                        : cond_reg;
          default: skip_reg <= 1'b0;
        endcase
      end
    end
  end

  // ****************************************************************
  // stack and memory ports
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ram_addr      <= 8'h00;
      ram_we        <= 1'b0;
      ram_wdata     <= 8'h00;
      rom_addr      <= 15'h0000;
      stack_pointer <= cft_pkg::SP_RESET;
    end else begin
      ram_we <= 1'b0;
      if (active && !(accept && skip_reg)) begin
        case (cur_op)
          cft_pkg::OP_CALL_FAR, cft_pkg::OP_CALL_NEAR, cft_pkg::OP_TRAP: begin
            if (cur_k == 3'h0) begin
              ram_addr  <= stack_pointer;
              ram_we    <= 1'b1;
              ram_wdata <= cur_ret[7:0];
            end else if (cur_k == 3'h1) begin
              ram_addr      <= stack_pointer - 8'h01;
              ram_we        <= 1'b1;
              ram_wdata     <= {1'b0, ret_addr_reg[14:8]};
              stack_pointer <= stack_pointer - 8'h02;
            end
          end
          // pop two, low byte from the upper slot
          cft_pkg::OP_EXIT, cft_pkg::OP_EXIT_SKIP, cft_pkg::OP_IRQ_EXIT: begin
            if (cur_k == 3'h0) begin
              ram_addr <= stack_pointer + 8'h02;
            end else if (cur_k == 3'h1) begin
              ram_addr      <= stack_pointer + 8'h01;
              stack_pointer <= stack_pointer + 8'h02;
            end
          end
          // accumulator push and pop on the stack
          cft_pkg::OP_ACC_PUSH: begin
            if (cur_k == 3'h0) begin
              ram_addr      <= stack_pointer;
              ram_we        <= 1'b1;
              ram_wdata     <= acc_value;
              stack_pointer <= stack_pointer - 8'h01;
            end
          end
          cft_pkg::OP_ACC_POP: begin
            if (cur_k == 3'h0) begin
              ram_addr      <= stack_pointer + 8'h01;
              stack_pointer <= stack_pointer + 8'h01;
            end
          end
          // table address from high part and accumulator
          cft_pkg::OP_TABLE_JUMP, cft_pkg::OP_ROM_LOAD: begin
            if (cur_k == 3'h0)
              rom_addr <= {pc[14:8], acc_value};
          end
          default: ram_we <= 1'b0;
        endcase
      end
    end
  end

  // ****************************************************************
  // program counter, accumulator write-back, interrupt enable
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pc                <= cft_pkg::PC_RESET;
      pc_tmp_reg        <= 15'h0000;
      acc_we            <= 1'b0;
      acc_wdata         <= 8'h00;
      global_irq_enable <= 1'b0;
    end else begin
      acc_we <= 1'b0;
      if (accept && skip_reg) begin
        // advance past the whole skipped instruction
        pc <= cur_ret;
      end else if (active) begin
        // restored bytes sampled one cycle after their address
        if (cur_k == 3'h1)
          pc_tmp_reg[7:0] <= (cur_op == cft_pkg::OP_TABLE_JUMP) ? rom_rdata
                                                                : ram_rdata;
        if (cur_k == 3'h2)
          pc_tmp_reg[14:8] <= ram_rdata[6:0];
        if (cur_k == 3'h1 && (cur_op == cft_pkg::OP_ROM_LOAD ||
                              cur_op == cft_pkg::OP_ACC_POP)) begin
          acc_we    <= 1'b1;
          acc_wdata <= (cur_op == cft_pkg::OP_ROM_LOAD) ? rom_rdata
                                                        : ram_rdata;
        end
        if (last_step) begin
          case (cur_op)
            cft_pkg::OP_CALL_FAR, cft_pkg::OP_FAR_JUMP, cft_pkg::OP_VECTOR:
              pc <= cur_operand;
            cft_pkg::OP_CALL_NEAR, cft_pkg::OP_PAGE_JUMP:
              pc <= {cur_ret[14:12], cur_operand[11:0]};
            cft_pkg::OP_SHORT_JUMP:
              pc <= pc + cur_operand;
            // only the low byte is loaded
            cft_pkg::OP_TABLE_JUMP:
              pc <= {pc[14:8], pc_tmp_reg[7:0]};
            cft_pkg::OP_EXIT, cft_pkg::OP_EXIT_SKIP:
              pc <= pc_tmp_reg;
            cft_pkg::OP_IRQ_EXIT: begin
              pc                <= pc_tmp_reg;
              global_irq_enable <= 1'b1;
            end
            cft_pkg::OP_TRAP:
              pc <= cft_pkg::TRAP_TARGET;
            default:
              pc <= cur_ret;
          endcase
        end
      end
    end
  end

endmodule : cft_sequencer

// ---- test/cft_mem_model.sv ----
// stack ram and program rom seen by the sequencer
`timescale 1ns/1ps
module cft_mem_model (
  // clock
  input wire logic        sys_clk,
  // stack ram
  input wire logic [7:0]  ram_addr,
  input wire logic        ram_we,
  input wire logic [7:0]  ram_wdata,
  output logic     [7:0]  ram_rdata,
  // program rom
  input wire logic [14:0] rom_addr,
  output logic     [7:0]  rom_rdata
);
  logic [7:0] mem [256];
  // a pattern, not zero, so a missed push cannot read back as correct
  initial foreach (mem[i]) mem[i] = 8'(i) ^ 8'ha5;
  always @(posedge sys_clk) if (ram_we) mem[ram_addr] <= ram_wdata;
  assign ram_rdata = mem[ram_addr];
  assign rom_rdata = rom_addr[7:0] ^ {1'b0, rom_addr[14:8]} ^ 8'h5a;
endmodule : cft_mem_model

// ---- test/cft_sequencer_checker.sv ----
// port-level assertions for the control-flow sequencer
`timescale 1ns/1ps
// ********
// checker
// ********
module cft_sequencer_checker (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        resetn,
  // issue side
  input wire logic        issue_valid,
  input wire logic [5:0]  issue_op,
  input wire logic [14:0] issue_operand,
  input wire logic [7:0]  acc_value,
  input wire logic        issue_ready,
  input wire logic        instr_done,
  input wire logic        instr_skipped,
  // state and memory ports
  input wire logic [14:0] pc,
  input wire logic [7:0]  stack_pointer,
  input wire logic        global_irq_enable,
  input wire logic [7:0]  ram_addr,
  input wire logic        ram_we,
  input wire logic [7:0]  ram_wdata,
  input wire logic [14:0] rom_addr,
  input wire logic        acc_we
);
  logic take;
  assign take = issue_ready && issue_valid;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // a skipped instruction ends at the first edge, so "##1 !instr_done"
  // keeps these to instructions that really execute
  a_idle_step: assert property (
    take && issue_op == cft_pkg::OP_IDLE |=> instr_done && !ram_we &&
    !acc_we && pc == $past(pc) + 15'h1)
    else $error("idle did not step pc by one");
  a_far_push: assert property (
    (take && issue_op == cft_pkg::OP_CALL_FAR) ##1 !instr_done |->
    ram_we && ram_addr == $past(stack_pointer) &&
    ram_wdata == 8'($past(pc) + 15'h3))
    else $error("far call pushed wrong low byte");
  a_far_target: assert property (
    (take && issue_op == cft_pkg::OP_CALL_FAR) ##1 !instr_done |->
    !instr_done [*4] ##1 (instr_done && pc == $past(issue_operand, 5)))
    else $error("far call target or timing wrong");
  a_near_push: assert property (
    (take && issue_op == cft_pkg::OP_CALL_NEAR) ##1 !instr_done |->
    ram_we && ram_wdata == 8'($past(pc) + 15'h2) ##1
    (ram_we && ram_addr == $past(stack_pointer, 2) - 8'h1))
    else $error("near call push wrong");
  a_exit_pop: assert property (
    (take && issue_op == cft_pkg::OP_EXIT) ##1 !instr_done |->
    ram_addr == $past(stack_pointer) + 8'h2 ##1
    stack_pointer == $past(stack_pointer, 2) + 8'h2 ##3 instr_done)
    else $error("return pop order or timing wrong");
  a_trap_vector: assert property (
    (take && issue_op == cft_pkg::OP_TRAP) ##1 !instr_done |->
    !instr_done [*6] ##1 (instr_done && pc == cft_pkg::TRAP_TARGET))
    else $error("trap target or timing wrong");
  a_gie_restore: assert property (
    (take && issue_op == cft_pkg::OP_IRQ_EXIT) ##1 !instr_done |->
    ##[0:4] (instr_done && global_irq_enable))
    else $error("irq exit left interrupts disabled");
  a_table_addr: assert property (
    (take && issue_op == cft_pkg::OP_TABLE_JUMP) ##1 !instr_done |->
    rom_addr[7:0] == $past(acc_value) ##2 instr_done)
    else $error("table jump address or timing wrong");
  a_pop_write: assert property (
    (take && issue_op == cft_pkg::OP_ACC_POP) ##1 !instr_done |->
    ##1 acc_we ##1 instr_done)
    else $error("pop did not write accumulator in time");
  a_skip_done: assert property (
    instr_skipped |-> instr_done && pc != $past(pc))
    else $error("skip pulse without completion");
  c_far_call: cover property (take && issue_op == cft_pkg::OP_CALL_FAR);
  c_trap: cover property (take && issue_op == cft_pkg::OP_TRAP);
  c_skip: cover property (instr_skipped);
endmodule : cft_sequencer_checker

bind cft_sequencer cft_sequencer_checker u_chk (
  .sys_clk, .resetn, .issue_valid, .issue_op, .issue_operand, .acc_value,
  .issue_ready, .instr_done, .instr_skipped, .pc, .stack_pointer,
  .global_irq_enable, .ram_addr, .ram_we, .ram_wdata, .rom_addr, .acc_we
);

// ---- test/tb.sv ----
// self-checking bench for the control-flow sequencer
`timescale 1ns/1ps
module tb;
  logic        sys_clk, resetn, issue_valid, issue_cond_fail;
  logic [5:0]  issue_op;
  logic [14:0] issue_operand, pc, rom_addr;
  logic [7:0]  acc_value, stack_pointer, ram_addr, ram_wdata, ram_rdata;
  logic [7:0]  rom_rdata, acc_wdata;
  logic        issue_ready, instr_done, instr_skipped, global_irq_enable;
  logic        ram_we, acc_we;
  int          failures, checks_done;
  cft_sequencer u_dut (.sys_clk, .resetn, .issue_valid, .issue_op,
    .issue_operand, .issue_cond_fail, .acc_value, .issue_ready, .instr_done,
    .instr_skipped, .pc, .stack_pointer, .global_irq_enable, .ram_addr,
    .ram_we, .ram_wdata, .ram_rdata, .rom_addr, .rom_rdata, .acc_we,
    .acc_wdata);
  cft_mem_model u_mem (.sys_clk, .ram_addr, .ram_we, .ram_wdata, .ram_rdata,
    .rom_addr, .rom_rdata);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ********
  // helpers
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // issue one instruction, n counts edges from acceptance to completion
  task automatic run(input logic [5:0] op, input logic [14:0] opd,
                     input logic cf, output int n);
    @(negedge sys_clk);
    issue_valid = 1'b1;
    issue_op = op;
    issue_operand = opd;
    issue_cond_fail = cf;
    while (issue_ready !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
    issue_valid = 1'b0;
    // done is registered: it stands from the edge after acceptance
    n = 1;
    while (instr_done !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
  endtask : run
  task automatic give_verdict;
    $display("failures %0d checks_done %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  // ********
  // scenarios
  // ********
  task automatic t_basic;
    int n;
    logic [14:0] p;
    chk(stack_pointer, 32'h6f);
    chk(global_irq_enable, 32'h0);
    p = pc;
    run(cft_pkg::OP_IDLE, 15'h0000, 1'b0, n);
    chk(n, 32'h1);
    chk(pc, p + 15'h1);
  endtask : t_basic
  task automatic t_timing;
    int n;
    logic [14:0] p;
    cft_pkg::cft_op_type ops [24] = '{cft_pkg::OP_ALU_B, cft_pkg::OP_ALU_DIR,
      cft_pkg::OP_ALU_IMM, cft_pkg::OP_BIT_B, cft_pkg::OP_BIT_DIR,
      cft_pkg::OP_DEC_SKIP, cft_pkg::OP_NIB_CMP, cft_pkg::OP_CLR_PEND,
      cft_pkg::OP_ACC, cft_pkg::OP_ROM_LOAD, cft_pkg::OP_ACC_PUSH,
      cft_pkg::OP_ACC_POP, cft_pkg::OP_MASK_SKIP, cft_pkg::OP_XFER_B,
      cft_pkg::OP_XFER_X, cft_pkg::OP_XFER_DIR, cft_pkg::OP_XFER_BIDX,
      cft_pkg::OP_XFER_XIDX, cft_pkg::OP_LD_A_IMM, cft_pkg::OP_MEM_IMM_B,
      cft_pkg::OP_MEM_IMM_D, cft_pkg::OP_REG_IMM, cft_pkg::OP_CMP_DIR_IM,
      cft_pkg::OP_LD_B_IMM};
    // bytes in the high nibble, cycles in the low nibble
    logic [7:0] bc [24] = '{8'h11, 8'h34, 8'h22, 8'h11, 8'h34, 8'h13, 8'h11,
      8'h11, 8'h11, 8'h13, 8'h13, 8'h13, 8'h22, 8'h11, 8'h13, 8'h23, 8'h12,
      8'h13, 8'h22, 8'h22, 8'h33, 8'h23, 8'h33, 8'h11};
    for (int i = 0; i < 24; i++) begin
      p = pc;
      run(ops[i], 15'h000f, 1'b0, n);
      chk(n, 32'(bc[i][3:0]));
      chk(pc, p + 15'(bc[i][7:4]));
    end
    p = pc;
    run(cft_pkg::OP_LD_B_IMM, 15'h0010, 1'b0, n);
    chk(n, 32'h2);
    chk(pc, p + 15'h2);
  endtask : t_timing
  task automatic t_jumps;
    int n;
    run(cft_pkg::OP_FAR_JUMP, 15'h0200, 1'b0, n);
    chk(n, 32'h4);
    chk(pc, 32'h0200);
    run(cft_pkg::OP_SHORT_JUMP, 15'h0004, 1'b0, n);
    chk(n, 32'h3);
    chk(pc, 32'h0204);
    run(cft_pkg::OP_PAGE_JUMP, 15'h0345, 1'b0, n);
    chk(n, 32'h3);
    chk(pc, 32'h0345);
    run(cft_pkg::OP_VECTOR, 15'h0100, 1'b0, n);
    chk(n, 32'h5);
    chk(pc, 32'h0100);
  endtask : t_jumps
  task automatic t_calls;
    int n;
    logic [14:0] p;
    logic [7:0] s;
    s = stack_pointer;
    p = pc;
    run(cft_pkg::OP_CALL_FAR, 15'h1234, 1'b0, n);
    chk(n, 32'h5);
    chk(pc, 32'h1234);
    chk(stack_pointer, s - 8'h2);
    chk(u_mem.mem[s], 8'(p + 15'h3));
    chk(u_mem.mem[s - 8'h1], (p + 15'h3) >> 8);
    run(cft_pkg::OP_EXIT, 15'h0000, 1'b0, n);
    chk(n, 32'h5);
    chk(pc, p + 15'h3);
    chk(stack_pointer, s);
    p = pc;
    run(cft_pkg::OP_CALL_NEAR, 15'h0abc, 1'b0, n);
    chk(n, 32'h5);
    chk(pc, {p[14:12], 12'habc});
    run(cft_pkg::OP_EXIT_SKIP, 15'h0000, 1'b0, n);
    chk(n, 32'h5);
    chk(pc, p + 15'h2);
    p = pc;
    // the three-byte instruction after the skipping return is passed over
    run(cft_pkg::OP_ALU_DIR, 15'h0000, 1'b0, n);
    chk(n, 32'h1);
    chk(instr_skipped, 32'h1);
    chk(pc, p + 15'h3);
    p = pc;
    run(cft_pkg::OP_TRAP, 15'h0000, 1'b0, n);
    chk(n, 32'h7);
    chk(pc, 32'h00ff);
    chk(stack_pointer, s - 8'h2);
    run(cft_pkg::OP_IRQ_EXIT, 15'h0000, 1'b0, n);
    chk(n, 32'h5);
    chk(pc, p + 15'h1);
    chk(global_irq_enable, 32'h1);
  endtask : t_calls
  task automatic t_table_skip;
    int n;
    logic [14:0] p;
    acc_value = 8'h37;
    p = pc;
    run(cft_pkg::OP_TABLE_JUMP, 15'h0000, 1'b0, n);
    chk(n, 32'h3);
    chk(pc, {p[14:8], 8'h37 ^ {1'b0, p[14:8]} ^ 8'h5a});
    p = pc;
    run(cft_pkg::OP_ROM_LOAD, 15'h0000, 1'b0, n);
    chk(n, 32'h3);
    chk(acc_wdata, 8'h37 ^ {1'b0, p[14:8]} ^ 8'h5a);
    chk(pc, p + 15'h1);
    run(cft_pkg::OP_ALU_IMM, 15'h0000, 1'b1, n);
    chk(n, 32'h2);
    p = pc;
    run(cft_pkg::OP_XFER_DIR, 15'h0000, 1'b0, n);
    chk(n, 32'h1);
    chk(pc, p + 15'h2);
  endtask : t_table_skip
  initial begin
    failures = 0;
    checks_done = 0;
    resetn = 1'b0;
    issue_valid = 1'b0;
    issue_op = 6'h00;
    issue_operand = 15'h0000;
    issue_cond_fail = 1'b0;
    acc_value = 8'h00;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    resetn = 1'b1;
    t_basic;
    t_timing;
    t_jumps;
    t_calls;
    t_table_skip;
    give_verdict;
  end
  // the whole run needs under two hundred cycles; this margin only cuts hangs
  initial begin
    repeat (4000) @(posedge sys_clk);
    failures++;
    give_verdict;
  end
endmodule : tb
